/* core/scr_config_bank.sv */
// How it works
// - 1x scale: 200 mV plus 5 mV steps
// - 4x scale: 800 mV plus 20 mV steps
// - Fast comparator results debounced, fields 7-4/3-0
// - Debounce code doubles from 0.1 us, caps 102.4
// - Corner code selects 250 Hz to 4 kHz
// - Bit 4 routes fast overvoltage to reset
// - Bit 3 routes fast undervoltage to reset
// - Error monitor must persist delay before fault
// - Bit 7 requests built-in self test
// - Watchdog enabled by bit 6 and pin
// - Bit 5 pulls reset output low
// - Error monitor debounce 10/25/50/100 us
// - Reset delay selected from eight values
// - Power-up auto-mask per channel bits 3..1
// - Power-down auto-mask per channel bits 3..1
// - Timeout built from high and low bytes
// - Power-up mask releases at selected threshold
module scr_config_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h30,
  parameter int TICK_CYC = 5000,
  parameter int GLITCH_LONG_CYC = 5120,
  parameter int ESM_GLITCH_LONG_CYC = 5000
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic voltage_range_scale_i,
  input wire logic fast_overvoltage_cmp_i,
  input wire logic fast_undervoltage_cmp_i,
  input wire logic error_signal_monitor_i,
  input wire logic watchdog_enable_pin_i,
  input wire logic power_up_phase_i,
  input wire logic power_down_phase_i,
  input wire logic [3:1] release_at_slow_uv_i,
  input wire logic [3:1] above_off_i,
  input wire logic [3:1] above_slow_uv_i,
  output logic [12:0] slow_under_limit_mv_o,
  output logic [12:0] slow_over_limit_mv_o,
  output logic fast_overvoltage_fault_o,
  output logic fast_undervoltage_fault_o,
  output logic [12:0] slow_corner_hz_o,
  output logic slow_corner_valid_o,
  output logic error_monitor_fault_o,
  output logic self_test_request_o,
  output logic watchdog_active_o,
  output logic [3:1] auto_mask_o,
  output logic [15:0] timeout_ms_count_o,
  output logic reset_out_n_o
);

  // ==========================================
  // Helpers
  function automatic logic [12:0] thr_mv(input logic [7:0] code, input logic scale4);
    thr_mv = scale4 ? scr_pkg::THR_BASE_4X_MV + 13'(code) * scr_pkg::THR_STEP_4X_MV
                    : scr_pkg::THR_BASE_1X_MV + 13'(code) * scr_pkg::THR_STEP_1X_MV;
  endfunction

  function automatic logic [15:0] glitch_cyc(input logic [3:0] code);
    glitch_cyc = (code >= scr_pkg::GLITCH_LONG_CODE) ? 16'(GLITCH_LONG_CYC)
                                                     : scr_pkg::GLITCH_BASE_CYC << code;
  endfunction

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
  localparam logic [15:0] ESM_G0 = 16'(scr_pkg::ESM_GLITCH_US[0] * 1000 / scr_pkg::CLK_NS);
  localparam logic [15:0] ESM_G1 = 16'(scr_pkg::ESM_GLITCH_US[1] * 1000 / scr_pkg::CLK_NS);
  localparam logic [15:0] ESM_G2 = 16'(scr_pkg::ESM_GLITCH_US[2] * 1000 / scr_pkg::CLK_NS);

  // ==========================================
  // I2C slave, pins sampled on clk_i
  scr_pkg::scr_i2c_st_e st_q;
  logic scl_q;
  logic sda_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [3:0] cnt_q;
  logic rw_q;
  logic drv_q;
  logic [7:0] rd_byte;
  scr_pkg::scr_wr_s wr;

  wire logic scl_rise = scl_i & ~scl_q;
  wire logic scl_fall = ~scl_i & scl_q;
  wire logic i2c_start = scl_i & scl_q & sda_q & ~sda_i;
  wire logic i2c_stop = scl_i & scl_q & ~sda_q & sda_i;
  wire logic byte_done = (cnt_q == scr_pkg::I2C_BITS);

  assign wr.en = scl_fall && (st_q == scr_pkg::ST_WR) && byte_done;
  assign wr.addr = ptr_q;
  assign wr.data = sh_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= scr_pkg::ST_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (i2c_start) begin
      st_q <= scr_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      drv_q <= 1'b0;
    end else if (i2c_stop) begin
      st_q <= scr_pkg::ST_IDLE;
      drv_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == scr_pkg::ST_ADDR || st_q == scr_pkg::ST_PTR || st_q == scr_pkg::ST_WR) begin
        sh_q <= {sh_q[6:0], sda_i};
        cnt_q <= cnt_q + 4'h1;
      end else if (st_q == scr_pkg::ST_RD_ACK && sda_i) begin
        st_q <= scr_pkg::ST_IDLE;
      end
    end else if (scl_fall) begin
      unique case (st_q)
        scr_pkg::ST_IDLE: begin
        end
        scr_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              st_q <= scr_pkg::ST_ADDR_ACK;
              rw_q <= sh_q[0];
              drv_q <= 1'b1;
            end else begin
              st_q <= scr_pkg::ST_IDLE;
            end
          end
        end
        scr_pkg::ST_ADDR_ACK, scr_pkg::ST_RD_ACK: begin
          if (st_q == scr_pkg::ST_ADDR_ACK && !rw_q) begin
            st_q <= scr_pkg::ST_PTR;
            drv_q <= 1'b0;
          end else begin
            st_q <= scr_pkg::ST_RD;
            tx_q <= {rd_byte[6:0], 1'b0};
            drv_q <= ~rd_byte[7];
            ptr_q <= ptr_q + 8'h01;
          end
          cnt_q <= 4'h1;
          if (st_q == scr_pkg::ST_ADDR_ACK && !rw_q) begin
            cnt_q <= 4'h0;
          end
        end
        scr_pkg::ST_PTR, scr_pkg::ST_WR: begin
          if (byte_done) begin
            st_q <= (st_q == scr_pkg::ST_PTR) ? scr_pkg::ST_PTR_ACK : scr_pkg::ST_WR_ACK;
            ptr_q <= (st_q == scr_pkg::ST_PTR) ? sh_q : ptr_q + 8'h01;
            drv_q <= 1'b1;
          end
        end
        scr_pkg::ST_PTR_ACK, scr_pkg::ST_WR_ACK: begin
          st_q <= scr_pkg::ST_WR;
          cnt_q <= 4'h0;
          drv_q <= 1'b0;
        end
        scr_pkg::ST_RD: begin
          if (byte_done) begin
            st_q <= scr_pkg::ST_RD_ACK;
            drv_q <= 1'b0;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            drv_q <= ~tx_q[7];
            cnt_q <= cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drv_q;

  // ==========================================
  // Register bank
  logic [7:0] under_q;
  logic [7:0] over_q;
  logic [7:0] glitch_q;
  logic [7:0] corner_q;
  logic [7:0] esm_dly_q;
  logic [7:0] safety_q;
  logic [7:0] power_up_auto_mask_q;
  logic [7:0] power_down_auto_mask_q;
  logic [7:0] tout_hi_q;
  logic [7:0] tout_lo_q;

  // Whole bytes are kept so reserved bits read back as written
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      under_q <= scr_pkg::REG_RESET;
      over_q <= scr_pkg::REG_RESET;
      glitch_q <= scr_pkg::REG_RESET;
      corner_q <= scr_pkg::REG_RESET;
      esm_dly_q <= scr_pkg::REG_RESET;
      safety_q <= scr_pkg::REG_RESET;
      power_up_auto_mask_q <= scr_pkg::REG_RESET;
      power_down_auto_mask_q <= scr_pkg::REG_RESET;
      tout_hi_q <= scr_pkg::REG_RESET;
      tout_lo_q <= scr_pkg::REG_RESET;
    end else if (wr.en) begin
      if (wr.addr == scr_pkg::OFS_CH4_SLOW_UNDER_LIMIT) under_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_CH4_SLOW_OVER_LIMIT) over_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_CH4_FAST_GLITCH_FILTER) glitch_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_CH4_SLOW_CORNER_AND_RESET_MAP) corner_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_ERROR_MONITOR_DELAY) esm_dly_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_SAFETY_CONTROL) safety_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_POWER_UP_AUTO_MASK) power_up_auto_mask_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_POWER_DOWN_AUTO_MASK) power_down_auto_mask_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_SEQUENCE_TIMEOUT_HIGH) tout_hi_q <= wr.data;
      if (wr.addr == scr_pkg::OFS_SEQUENCE_TIMEOUT_LOW) tout_lo_q <= wr.data;
    end
  end

  assign rd_byte =
    (ptr_q == scr_pkg::OFS_CH4_SLOW_UNDER_LIMIT) ? under_q :
    (ptr_q == scr_pkg::OFS_CH4_SLOW_OVER_LIMIT) ? over_q :
    (ptr_q == scr_pkg::OFS_CH4_FAST_GLITCH_FILTER) ? glitch_q :
    (ptr_q == scr_pkg::OFS_CH4_SLOW_CORNER_AND_RESET_MAP) ? corner_q :
    (ptr_q == scr_pkg::OFS_ERROR_MONITOR_DELAY) ? esm_dly_q :
    (ptr_q == scr_pkg::OFS_SAFETY_CONTROL) ? safety_q :
    (ptr_q == scr_pkg::OFS_POWER_UP_AUTO_MASK) ? power_up_auto_mask_q :
    (ptr_q == scr_pkg::OFS_POWER_DOWN_AUTO_MASK) ? power_down_auto_mask_q :
    (ptr_q == scr_pkg::OFS_SEQUENCE_TIMEOUT_HIGH) ? tout_hi_q :
    (ptr_q == scr_pkg::OFS_SEQUENCE_TIMEOUT_LOW) ? tout_lo_q : scr_pkg::READ_UNMAPPED;

  // ==========================================
  // Field decode
  wire logic [3:0] ov_time = glitch_q[scr_pkg::OV_TIME_LSB +: 4];
  wire logic [3:0] uv_time = glitch_q[scr_pkg::UV_TIME_LSB +: 4];
  wire logic [2:0] corner_code = corner_q[scr_pkg::CORNER_LSB +: 3];
  wire logic [1:0] esm_glitch_code = safety_q[scr_pkg::ESM_GLITCH_LSB +: 2];
  wire logic [2:0] hold_sel = safety_q[scr_pkg::RST_HOLD_LSB +: 3];
  wire logic soft_manual_reset = safety_q[scr_pkg::SOFT_MR_BIT];

  wire logic [12:0] corner_hz =
    (corner_code == scr_pkg::CORNER_250) ? scr_pkg::HZ_250 :
    (corner_code == scr_pkg::CORNER_500) ? scr_pkg::HZ_500 :
    (corner_code == scr_pkg::CORNER_1K) ? scr_pkg::HZ_1K :
    (corner_code == scr_pkg::CORNER_2K) ? scr_pkg::HZ_2K :
    (corner_code == scr_pkg::CORNER_4K) ? scr_pkg::HZ_4K : 13'd0;

  wire logic [15:0] esm_glitch_lim =
    (esm_glitch_code == 2'h0) ? ESM_G0 :
    (esm_glitch_code == 2'h1) ? ESM_G1 :
    (esm_glitch_code == 2'h2) ? ESM_G2 : 16'(ESM_GLITCH_LONG_CYC);

  // Linear map of the code onto 1..864 ms, counted in 100 us ticks
  wire logic [15:0] esm_ms = 16'(scr_pkg::ESM_MIN_MS) + 16'((32'(esm_dly_q)
    * 32'(scr_pkg::ESM_MAX_MS - scr_pkg::ESM_MIN_MS)) / scr_pkg::ESM_CODE_MAX);
  wire logic [15:0] esm_ticks = 16'(32'(esm_ms) * (scr_pkg::MS_US / scr_pkg::TICK_US));

  wire logic [15:0] hold_ticks = 16'(scr_pkg::RST_HOLD_US[hold_sel] / scr_pkg::TICK_US);

  // ==========================================
  // Time base, 100 us
  logic [15:0] tick_cnt_q;
  wire logic tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // ==========================================
  // Filters
  logic ov_filt;
  logic uv_filt;
  logic error_monitor_glitch_time;
  logic esm_fault;

  scr_glitch_filter #(.CW(16)) u_ov_filt (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_i(1'b1),
    .raw_i(fast_overvoltage_cmp_i), .limit_i(glitch_cyc(ov_time)), .filt_o(ov_filt)
  );

  scr_glitch_filter #(.CW(16)) u_uv_filt (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_i(1'b1),
    .raw_i(fast_undervoltage_cmp_i), .limit_i(glitch_cyc(uv_time)), .filt_o(uv_filt)
  );

  scr_glitch_filter #(.CW(16)) u_error_monitor_glitch_time (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_i(1'b1),
    .raw_i(error_signal_monitor_i), .limit_i(esm_glitch_lim), .filt_o(error_monitor_glitch_time)
  );

  // Resolution is one tick, so the persist time may run short by up to 100 us
  scr_glitch_filter #(.CW(16)) u_esm_dly (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_i(tick),
    .raw_i(error_monitor_glitch_time), .limit_i(esm_ticks), .filt_o(esm_fault)
  );

  // ==========================================
  // Auto-mask
  wire logic [3:1] up_reached = (release_at_slow_uv_i & above_slow_uv_i)
                              | (~release_at_slow_uv_i & above_off_i);
  wire logic [3:1] mask_d = ({3{power_up_phase_i}} & power_up_auto_mask_q[3:1] & ~up_reached)
                          | ({3{power_down_phase_i}} & power_down_auto_mask_q[3:1]);

  // ==========================================
  // Reset output
  wire logic ov_route = ov_filt & ~mask_d[scr_pkg::CH_FOUR] & corner_q[scr_pkg::ROUTE_OV_BIT];
  wire logic uv_route = uv_filt & ~mask_d[scr_pkg::CH_FOUR] & corner_q[scr_pkg::ROUTE_UV_BIT];
  wire logic reset_req = ov_route | uv_route | soft_manual_reset;

  logic rst_n_q;
  logic [15:0] hold_cnt_q;
  wire logic [15:0] hold_inc = hold_cnt_q + 16'h0001;

  // Release only after the hold delay runs with no request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || reset_req) begin
      rst_n_q <= 1'b0;
      hold_cnt_q <= 16'h0000;
    end else if (!rst_n_q && tick) begin
      if (hold_inc >= hold_ticks) begin
        rst_n_q <= 1'b1;
      end
      hold_cnt_q <= hold_inc;
    end
  end

  // ==========================================
  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      slow_under_limit_mv_o <= 13'd0;
      slow_over_limit_mv_o <= 13'd0;
      slow_corner_hz_o <= 13'd0;
      slow_corner_valid_o <= 1'b0;
      self_test_request_o <= 1'b0;
      watchdog_active_o <= 1'b0;
      auto_mask_o <= 3'h0;
      timeout_ms_count_o <= 16'h0000;
    end else begin
      slow_under_limit_mv_o <= thr_mv(under_q, voltage_range_scale_i);
      slow_over_limit_mv_o <= thr_mv(over_q, voltage_range_scale_i);
      slow_corner_hz_o <= corner_hz;
      slow_corner_valid_o <= (corner_hz != 13'd0);
      self_test_request_o <= safety_q[scr_pkg::SELF_TEST_BIT];
      watchdog_active_o <= safety_q[scr_pkg::WDOG_SOFT_BIT] & watchdog_enable_pin_i;
      auto_mask_o <= mask_d;
      timeout_ms_count_o <= {tout_hi_q, tout_lo_q};
    end
  end

  assign fast_overvoltage_fault_o = ov_filt;
  assign fast_undervoltage_fault_o = uv_filt;
  assign error_monitor_fault_o = esm_fault;
  assign reset_out_n_o = rst_n_q;

endmodule

/* core/scr_glitch_filter.sv */
module scr_glitch_filter #(
  parameter int CW = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic raw_i,
  input wire logic [CW-1:0] limit_i,
  output logic filt_o
);

  logic [CW-1:0] cnt_q;
  logic filt_q;
  wire logic [CW-1:0] cnt_inc = cnt_q + CW'(1);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (raw_i == filt_q) begin
      cnt_q <= '0;
    end else if (tick_i) begin
      if (cnt_inc >= limit_i) begin
        filt_q <= raw_i;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_inc;
      end
    end
  end

  assign filt_o = filt_q;

endmodule

/* core/scr_pkg.sv */
package scr_pkg;

  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_CH4_SLOW_UNDER_LIMIT = 8'h52;
  localparam logic [7:0] OFS_CH4_SLOW_OVER_LIMIT = 8'h53;
  localparam logic [7:0] OFS_CH4_FAST_GLITCH_FILTER = 8'h54;
  localparam logic [7:0] OFS_CH4_SLOW_CORNER_AND_RESET_MAP = 8'h55;
  localparam logic [7:0] OFS_ERROR_MONITOR_DELAY = 8'h9E;
  localparam logic [7:0] OFS_SAFETY_CONTROL = 8'h9F;
  localparam logic [7:0] OFS_POWER_UP_AUTO_MASK = 8'hA1;
  localparam logic [7:0] OFS_POWER_DOWN_AUTO_MASK = 8'hA2;
  localparam logic [7:0] OFS_SEQUENCE_TIMEOUT_HIGH = 8'hA5;
  localparam logic [7:0] OFS_SEQUENCE_TIMEOUT_LOW = 8'hA6;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ==========================================
  // Field positions
  localparam int OV_TIME_LSB = 4;
  localparam int UV_TIME_LSB = 0;
  localparam int CORNER_LSB = 0;
  localparam int ROUTE_OV_BIT = 4;
  localparam int ROUTE_UV_BIT = 3;
  localparam int SELF_TEST_BIT = 7;
  localparam int WDOG_SOFT_BIT = 6;
  localparam int SOFT_MR_BIT = 5;
  localparam int ESM_GLITCH_LSB = 3;
  localparam int RST_HOLD_LSB = 0;
  localparam int CH_FOUR = 3;

  // ==========================================
  // Threshold scaling
  localparam logic [12:0] THR_BASE_1X_MV = 13'd200;
  localparam logic [12:0] THR_STEP_1X_MV = 13'd5;
  localparam logic [12:0] THR_BASE_4X_MV = 13'd800;
  localparam logic [12:0] THR_STEP_4X_MV = 13'd20;

  // ==========================================
  // Filter corner codes and frequencies
  localparam logic [2:0] CORNER_250 = 3'h2;
  localparam logic [2:0] CORNER_500 = 3'h3;
  localparam logic [2:0] CORNER_1K = 3'h4;
  localparam logic [2:0] CORNER_2K = 3'h5;
  localparam logic [2:0] CORNER_4K = 3'h6;
  localparam logic [12:0] HZ_250 = 13'd250;
  localparam logic [12:0] HZ_500 = 13'd500;
  localparam logic [12:0] HZ_1K = 13'd1000;
  localparam logic [12:0] HZ_2K = 13'd2000;
  localparam logic [12:0] HZ_4K = 13'd4000;

  // ==========================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int GLITCH_BASE_NS = 100;
  localparam logic [15:0] GLITCH_BASE_CYC = 16'((GLITCH_BASE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] GLITCH_LONG_CODE = 4'hA;
  localparam int GLITCH_LONG_NS = 102400;
  localparam int ESM_GLITCH_US [4] = '{10, 25, 50, 100};
  localparam int TICK_US = 100;
  localparam int MS_US = 1000;
  localparam int RST_HOLD_US [8] = '{200, 1000, 10000, 16000, 20000, 70000, 100000, 200000};
  localparam int ESM_MIN_MS = 1;
  localparam int ESM_MAX_MS = 864;
  localparam int ESM_CODE_MAX = 255;
  localparam logic [3:0] I2C_BITS = 4'd8;

  // ==========================================
  // Types
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } scr_wr_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } scr_i2c_st_e;

endpackage

/* sim/scr_config_bank_assertions.sv */
module scr_config_bank_assertions #(
  parameter int TICK_CYC = 5000
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic fast_overvoltage_cmp_i,
  input wire logic fast_undervoltage_cmp_i,
  input wire logic error_signal_monitor_i,
  input wire logic watchdog_enable_pin_i,
  input wire logic power_up_phase_i,
  input wire logic power_down_phase_i,
  input wire logic fast_overvoltage_fault_o,
  input wire logic fast_undervoltage_fault_o,
  input wire logic [12:0] slow_corner_hz_o,
  input wire logic slow_corner_valid_o,
  input wire logic error_monitor_fault_o,
  input wire logic watchdog_active_o,
  input wire logic [3:1] auto_mask_o,
  input wire logic reset_out_n_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ==========================================
  // Run lengths
  logic [15:0] esm_run_q;
  logic [15:0] low_run_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      esm_run_q <= 16'h0;
      low_run_q <= 16'h0;
    end else begin
      esm_run_q <= error_signal_monitor_i ? esm_run_q + 16'h1 : 16'h0;
      low_run_q <= reset_out_n_o ? 16'h0 : low_run_q + 16'h1;
    end
  end

  // ==========================================
  // Properties
  reset_in_a: assert property (disable iff (1'b0) sys_rst_i |=> !reset_out_n_o)
    else $error("reset high in reset");
  reset_hold_a: assert property ($rose(reset_out_n_o) |-> low_run_q >= 16'(TICK_CYC))
    else $error("reset released early");
  ov_rise_a: assert property ($rose(fast_overvoltage_fault_o) |->
    $past(fast_overvoltage_cmp_i, 1) && $past(fast_overvoltage_cmp_i, 4)) else $error("ov fault early");
  ov_fall_a: assert property ($fell(fast_overvoltage_fault_o) |->
    !$past(fast_overvoltage_cmp_i, 1) && !$past(fast_overvoltage_cmp_i, 4)) else $error("ov clear early");
  uv_rise_a: assert property ($rose(fast_undervoltage_fault_o) |->
    $past(fast_undervoltage_cmp_i, 1) && $past(fast_undervoltage_cmp_i, 4)) else $error("uv fault early");
  esm_persist_a: assert property ($rose(error_monitor_fault_o) |-> esm_run_q >= 16'h01F4)
    else $error("esm fault early");
  wdog_pin_a: assert property (!watchdog_enable_pin_i |=> !watchdog_active_o)
    else $error("watchdog without pin");
  mask_idle_a: assert property (!power_up_phase_i && !power_down_phase_i |=> auto_mask_o == 3'h0)
    else $error("mask outside phases");
  corner_set_a: assert property (slow_corner_valid_o |->
    slow_corner_hz_o inside {13'h0FA, 13'h1F4, 13'h3E8, 13'h7D0, 13'hFA0}) else $error("bad corner");
  corner_bad_a: assert property (!slow_corner_valid_o |-> slow_corner_hz_o == 13'h0)
    else $error("bad corner hz");
endmodule

bind scr_config_bank scr_config_bank_assertions #(.TICK_CYC(TICK_CYC)) i_chk (
  .clk_i, .sys_rst_i, .fast_overvoltage_cmp_i, .fast_undervoltage_cmp_i, .error_signal_monitor_i,
  .watchdog_enable_pin_i, .power_up_phase_i, .power_down_phase_i, .fast_overvoltage_fault_o,
  .fast_undervoltage_fault_o, .slow_corner_hz_o, .slow_corner_valid_o, .error_monitor_fault_o,
  .watchdog_active_o, .auto_mask_o, .reset_out_n_o
);

/* sim/scr_config_bank_tb.sv */
module scr_config_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] OFS [10] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h9E, 8'h9F, 8'hA1, 8'hA2, 8'hA5, 8'hA6};
  localparam logic [7:0] PAT [10] = '{8'h10, 8'hFF, 8'h01, 8'hE2, 8'h00, 8'h18, 8'hF5, 8'h0A, 8'h12, 8'h34};
  localparam logic [12:0] HZ [8] = '{13'h0, 13'h0, 13'h0FA, 13'h1F4, 13'h3E8, 13'h7D0, 13'hFA0, 13'h0};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl, sda_low, sda_o, oe_n, scale, ov_cmp, uv_cmp, error_monitor_delay, wd_pin, up_ph, dn_ph;
  logic ov_flt, uv_flt, hz_ok, esm_flt, bist, wd_act, rst_n;
  logic [3:1] rel, abv_off, abv_uv, mask;
  logic [12:0] uv_mv, ov_mv, hz;
  logic [15:0] tout;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  wire sda = ~(sda_low | ~oe_n);

  scr_config_bank #(.TICK_CYC(10), .GLITCH_LONG_CYC(50), .ESM_GLITCH_LONG_CYC(40)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n),
    .voltage_range_scale_i(scale), .fast_overvoltage_cmp_i(ov_cmp), .fast_undervoltage_cmp_i(uv_cmp),
    .error_signal_monitor_i(error_monitor_delay), .watchdog_enable_pin_i(wd_pin), .power_up_phase_i(up_ph),
    .power_down_phase_i(dn_ph), .release_at_slow_uv_i(rel), .above_off_i(abv_off), .above_slow_uv_i(abv_uv),
    .slow_under_limit_mv_o(uv_mv), .slow_over_limit_mv_o(ov_mv), .fast_overvoltage_fault_o(ov_flt),
    .fast_undervoltage_fault_o(uv_flt), .slow_corner_hz_o(hz), .slow_corner_valid_o(hz_ok),
    .error_monitor_fault_o(esm_flt), .self_test_request_o(bist), .watchdog_active_o(wd_act),
    .auto_mask_o(mask), .timeout_ms_count_o(tout), .reset_out_n_o(rst_n)
  );
  scr_i2c_host i_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      close_out();
    end
  end

  // ==========================================
  // Helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_host.wr(a, d, ok);
    chk("write ack", 16'h1, 16'(ok));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic ok;
    logic [7:0] d;
    i_host.rd(a, d, ok);
    chk("read ack", 16'h1, 16'(ok));
    chk("read data", 16'(e), 16'(d));
  endtask
  task automatic drv(input int s, input logic v);
    @(negedge clk_i);
    case (s)
      0: ov_cmp = v;
      1: uv_cmp = v;
      default: error_monitor_delay = v;
    endcase
  endtask
  task automatic lat(input int s, input int e, input int t);
    int n = 0;
    drv(s, 1'b1);
    while ((s == 0 ? ov_flt : s == 1 ? uv_flt : esm_flt) !== 1'b1 && n < 9000) begin
      @(negedge clk_i);
      n++;
    end
    chk("latency", 16'(e), (n < e - t || n > e + t) ? 16'(n) : 16'(e));
    drv(s, 1'b0);
    repeat (3000) @(negedge clk_i);
  endtask
  task automatic pulse(input int s, input logic e);
    drv(s, 1'b1);
    repeat (10) @(negedge clk_i);
    chk("reset level", 16'(e), 16'(rst_n));
    drv(s, 1'b0);
    repeat (40) @(negedge clk_i);
    chk("reset level", 16'h1, 16'(rst_n));
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    foreach (OFS[i]) rdc(OFS[i], 8'h00);
    rdc(8'h60, 8'h00);
    foreach (OFS[i]) wr(OFS[i], PAT[i]);
    foreach (OFS[i]) rdc(OFS[i], PAT[i]);
    chk("under mv", 16'h0118, 16'(uv_mv));
    chk("over mv", 16'h05C3, 16'(ov_mv));
    chk("timeout", 16'h1234, tout);
    scale = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("under mv", 16'h0460, 16'(uv_mv));
    chk("over mv", 16'h170C, 16'(ov_mv));
    scale = 1'b0;
  endtask
  task automatic t_corner();
    for (int c = 0; c < 8; c++) begin
      wr(8'h55, 8'(c));
      chk("corner hz", 16'(HZ[c]), 16'(hz));
      chk("corner ok", 16'(HZ[c] != 13'h0), 16'(hz_ok));
    end
  endtask
  task automatic t_filter();
    drv(0, 1'b1);
    repeat (3) @(negedge clk_i);
    drv(0, 1'b0);
    repeat (8) @(negedge clk_i);
    chk("short glitch", 16'h0, 16'(ov_flt));
    lat(0, 6, 1);
    lat(1, 11, 1);
    wr(8'h54, 8'hA9);
    lat(0, 51, 1);
    lat(1, 2561, 2);
  endtask
  task automatic t_route();
    wr(8'h54, 8'h00);
    wr(8'h55, 8'h00);
    pulse(0, 1'b1);
    pulse(1, 1'b1);
    wr(8'h55, 8'h10);
    pulse(0, 1'b0);
    pulse(1, 1'b1);
    wr(8'h55, 8'h08);
    pulse(1, 1'b0);
    wr(8'h9F, 8'h21);
    chk("soft reset", 16'h0, 16'(rst_n));
    wr(8'h9F, 8'h01);
    repeat (60) @(negedge clk_i);
    chk("reset hold", 16'h0, 16'(rst_n));
    repeat (60) @(negedge clk_i);
    chk("reset hold", 16'h1, 16'(rst_n));
  endtask
  task automatic t_safety();
    wr(8'h9F, 8'hC0);
    wd_pin = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("self test", 16'h1, 16'(bist));
    chk("watchdog", 16'h1, 16'(wd_act));
    wd_pin = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("watchdog", 16'h0, 16'(wd_act));
    wr(8'h9F, 8'h80);
    wd_pin = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("watchdog", 16'h0, 16'(wd_act));
    wr(8'h9F, 8'h00);
    chk("self test", 16'h0, 16'(bist));
  endtask
  task automatic t_mask();
    wr(8'hA1, 8'h0E);
    wr(8'hA2, 8'h04);
    rel = 3'b010;
    up_ph = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("mask", 16'h7, 16'(mask));
    abv_off = 3'b111;
    repeat (2) @(negedge clk_i);
    chk("mask", 16'h2, 16'(mask));
    abv_uv = 3'b010;
    repeat (2) @(negedge clk_i);
    chk("mask", 16'h0, 16'(mask));
    up_ph = 1'b0;
    dn_ph = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("mask", 16'h2, 16'(mask));
    wr(8'hA2, 8'h08);
    wr(8'h55, 8'h10);
    pulse(0, 1'b1);
    dn_ph = 1'b0;
  endtask
  task automatic t_esm();
    lat(2, 601, 15);
    wr(8'h9E, 8'h01);
    wr(8'h9F, 8'h08);
    lat(2, 1651, 15);
  endtask

  initial begin
    {scale, ov_cmp, uv_cmp, error_monitor_delay, wd_pin, up_ph, dn_ph} = 7'h0;
    {rel, abv_off, abv_uv} = 9'h0;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk("reset out", 16'h0, 16'(rst_n));
    t_regs();
    t_corner();
    t_filter();
    t_route();
    t_safety();
    t_mask();
    t_esm();
    close_out();
  end
endmodule

/* sim/scr_i2c_host.sv */
module scr_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h30
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // ==========================================
  // Bus phases
  task automatic ph(input logic s, input logic d);
    repeat (4) @(negedge clk_i);
    scl_o = s;
    sda_low_o = d;
  endtask
  task automatic bit_x(input logic v, output logic r);
    ph(1'b0, ~v);
    ph(1'b1, ~v);
    ph(1'b1, ~v);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start();
    ph(scl_o, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask
  task automatic stop();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  task automatic put(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ok = ok & ~r;
  endtask

  // ==========================================
  // Register cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    put({DEV_ADDR, 1'b0}, ok);
    put(a, ok);
    put(d, ok);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic r;
    ok = 1'b1;
    start();
    put({DEV_ADDR, 1'b0}, ok);
    put(a, ok);
    start();
    put({DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(1'b1, r);
    stop();
  endtask
endmodule
